// ===== daopc_params.svh
// Constants of the dual-converter output and power control block.
// Assumes inclusion by bare name in every file that needs them.
`ifndef DAOPC_PARAMS_SVH
`define DAOPC_PARAMS_SVH

`define DAOPC_WORD_W           10
`define DAOPC_CLK_PERIOD_NS    8
`define DAOPC_NAP_WAKE_SAMPLES 100
`define DAOPC_SLEEP_WAKE_MS    2
`define DAOPC_SLEEP_WAKE_CYCLES \
   ((`DAOPC_SLEEP_WAKE_MS * 1000000 + `DAOPC_CLK_PERIOD_NS - 1) / `DAOPC_CLK_PERIOD_NS)
`define DAOPC_CNT_W            18

`define DAOPC_OFS_CTRL         8'h00
`define DAOPC_OFS_STATUS       8'h04
`define DAOPC_OFS_IRQ_STAT     8'h08
`define DAOPC_OFS_IRQ_MASK     8'h0c

`define DAOPC_CTRL_A_PD        0
`define DAOPC_CTRL_A_HZ        1
`define DAOPC_CTRL_B_PD        2
`define DAOPC_CTRL_B_HZ        3
`define DAOPC_CTRL_SWAP        4
`define DAOPC_CTRL_SWAP_CLK    5
`define DAOPC_CTRL_W           6
`define DAOPC_CTRL_RESET       6'h10

`define DAOPC_IRQ_A_READY      0
`define DAOPC_IRQ_B_READY      1
`define DAOPC_IRQ_A_OVER       2
`define DAOPC_IRQ_B_OVER       3
`define DAOPC_IRQ_W            4

`endif

// ===== daopc_pkg.sv
// Types shared by the output and power control block.
// Assumes nothing of its surroundings.
package daopc_pkg;
   typedef enum logic [1:0] {
      CH_NORMAL = 2'b00,
      CH_NAP    = 2'b01,
      CH_SLEEP  = 2'b10,
      CH_WAKE   = 2'b11
   } daopc_mode_t;
endpackage : daopc_pkg

// ===== daopc_chan_if.sv
// Bundle between the top and one channel controller.
// Assumes daopc_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "daopc_params.svh"
interface daopc_chan_if;
   logic                       sample_en;
   logic                       pd;
   logic                       hz;
   logic [`DAOPC_WORD_W-1:0]   code;
   logic                       above;
   logic                       below;
   logic [`DAOPC_WORD_W-1:0]   word;
   logic                       of;
   logic                       out_en;
   logic                       valid;
   daopc_pkg::daopc_mode_t     mode;
   logic                       ref_on;
   logic                       run;
   modport ctl  (output sample_en, pd, hz, code, above, below,
                 input  word, of, out_en, valid, mode, ref_on, run);
   modport chan (input  sample_en, pd, hz, code, above, below,
                 output word, of, out_en, valid, mode, ref_on, run);
endinterface : daopc_chan_if
`default_nettype wire

// ===== daopc_chan.sv
// Power state, wake timing and sample capture of one converter channel.
// Assumes sample_en is a one-cycle pulse per sample clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "daopc_params.svh"
module daopc_chan #(
   parameter int unsigned NAP_WAKE   = `DAOPC_NAP_WAKE_SAMPLES,
   parameter int unsigned SLEEP_WAKE = `DAOPC_SLEEP_WAKE_CYCLES,
   parameter int unsigned CNT_W      = `DAOPC_CNT_W
) (
   input wire logic     core_clk,  // Core clock
   input wire logic     sys_rst,   // Synchronous reset, active high
   daopc_chan_if.chan   ch         // Controls in, channel state out
);
   daopc_pkg::daopc_mode_t   state_ff;
   daopc_pkg::daopc_mode_t   nxt_state;
   logic [CNT_W-1:0]         cnt_ff;
   logic                     from_sleep_ff;
   logic                     out_en_ff;
   logic [`DAOPC_WORD_W-1:0] word_ff;
   logic                     of_ff;

   // ----------------------------------------
   // Mode selection
   // ----------------------------------------
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         daopc_pkg::CH_NORMAL: begin
            if (ch.pd) nxt_state = ch.hz ? daopc_pkg::CH_SLEEP : daopc_pkg::CH_NAP; // [R04] [R06]
         end
         daopc_pkg::CH_NAP: begin
            if (!ch.pd) nxt_state = daopc_pkg::CH_WAKE;
            else if (ch.hz) nxt_state = daopc_pkg::CH_SLEEP; // [R04]
         end
         daopc_pkg::CH_SLEEP: begin
            if (!ch.pd) nxt_state = daopc_pkg::CH_WAKE;
            else if (!ch.hz) nxt_state = daopc_pkg::CH_NAP; // [R06]
         end
         daopc_pkg::CH_WAKE: begin
            if (ch.pd) nxt_state = ch.hz ? daopc_pkg::CH_SLEEP : daopc_pkg::CH_NAP;
            else if (cnt_ff == '0) nxt_state = daopc_pkg::CH_NORMAL; // [R03]
         end
         default: nxt_state = daopc_pkg::CH_NORMAL;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) state_ff <= daopc_pkg::CH_NORMAL;
      else state_ff <= nxt_state;
   end

   // Sleep recovery counts core cycles since the reference is recharging;
   // nap recovery counts sample clocks.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_ff        <= '0;
         from_sleep_ff <= 1'b0;
      end else if (state_ff != daopc_pkg::CH_WAKE && nxt_state == daopc_pkg::CH_WAKE) begin
         from_sleep_ff <= (state_ff == daopc_pkg::CH_SLEEP);
         cnt_ff <= (state_ff == daopc_pkg::CH_SLEEP) ? CNT_W'(SLEEP_WAKE)
                                                     : CNT_W'(NAP_WAKE); // [R05] [R06]
      end else if (state_ff == daopc_pkg::CH_WAKE && cnt_ff != '0 &&
                   (from_sleep_ff || ch.sample_en)) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end

   // ----------------------------------------
   // Output enable and sample capture
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) out_en_ff <= 1'b0;
      else out_en_ff <= !ch.hz && (nxt_state == daopc_pkg::CH_NORMAL ||
                                   nxt_state == daopc_pkg::CH_WAKE); // [R01] [R07] [R08]
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         word_ff <= '0;
         of_ff   <= 1'b0;
      end else if (ch.sample_en && ch.run) begin
         word_ff <= ch.code;
         of_ff   <= ch.above || ch.below; // [R13]
      end
   end

   assign ch.mode   = state_ff;
   assign ch.out_en = out_en_ff;
   assign ch.word   = word_ff;
   assign ch.of     = of_ff;
   assign ch.valid  = (state_ff == daopc_pkg::CH_NORMAL); // [R05]
   assign ch.ref_on = (state_ff != daopc_pkg::CH_SLEEP); // [R04]
   assign ch.run    = (state_ff == daopc_pkg::CH_NORMAL) || (state_ff == daopc_pkg::CH_WAKE);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence nap_req_s;
      state_ff == daopc_pkg::CH_NORMAL && ch.pd && !ch.hz;
   endsequence
   sequence sleep_req_s;
      state_ff == daopc_pkg::CH_NORMAL && ch.pd && ch.hz;
   endsequence

   nap_entry_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
      nap_req_s |=> state_ff == daopc_pkg::CH_NAP && ch.ref_on && !ch.out_en)
      else $error("Nap request did not reach nap.");
   sleep_entry_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R04]
      sleep_req_s |=> state_ff == daopc_pkg::CH_SLEEP && !ch.ref_on)
      else $error("Sleep request did not reach sleep.");
   highz_out_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R01]
      ch.hz |=> !ch.out_en)
      else $error("Outputs driven while high impedance requested.");
   lowpower_off_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R07]
      (state_ff == daopc_pkg::CH_NAP || state_ff == daopc_pkg::CH_SLEEP) |-> !ch.out_en)
      else $error("Outputs driven in nap or sleep.");
   normal_run_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R03]
      (state_ff == daopc_pkg::CH_NORMAL && !ch.pd && !ch.hz)[*2] |-> ch.out_en && ch.valid)
      else $error("Normal channel not driving.");
   sleep_wake_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R05]
      (state_ff == daopc_pkg::CH_SLEEP && !ch.pd) |=>
         state_ff == daopc_pkg::CH_WAKE && cnt_ff == CNT_W'(SLEEP_WAKE) && !ch.valid)
      else $error("Sleep exit did not load the settling count.");
   nap_wake_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R06]
      (state_ff == daopc_pkg::CH_NAP && !ch.pd) |=> cnt_ff == CNT_W'(NAP_WAKE) ##1
      (cnt_ff == CNT_W'(NAP_WAKE) || ch.pd || $past(ch.sample_en)))
      else $error("Nap exit count wrong.");
   wake_done_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R05]
      (state_ff == daopc_pkg::CH_WAKE && cnt_ff == '0 && !ch.pd) |=> ch.valid)
      else $error("Channel not valid after recovery.");
   overrange_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R13]
      (ch.sample_en && ch.run && (ch.above || ch.below)) |=> ch.of)
      else $error("Overrange flag missing.");
endmodule : daopc_chan
`default_nettype wire

// ===== daopc_top.sv
// Output and power control of a dual 10-bit converter, AHB-Lite registers.
// Assumes core code and range inputs are synchronous to core_clk; sample
// clock pins are asynchronous and are synchronised here.
//
// Notes on behaviour
// R01: Channel high-impedance request floats that channel's data and overrange outputs.
// R02: Software should toggle high impedance only across long idle periods.
// R03: Power-down low runs the channel normally, outputs gated only by high impedance.
// R04: Power-down with high impedance enters sleep, reference off too.
// R05: After sleep, data stays invalid for milliseconds while the reference settles.
// R06: Power-down without high impedance naps; data valid 100 sample clocks after release.
// R07: Nap and sleep float every output of the affected channel.
// R08: Each channel's state follows only its own power-down and high-impedance bits.
// R09: Swap select high: channel A on bus A, channel B on bus B.
// R10: Swap select low: channel A on bus B, channel B on bus A.
// R11: Interleaving needs swap select and both sample clocks from one signal.
// R12: In interleaving the unused bus may be floated by its high-impedance bit.
// R13: Overrange flag is high whenever the input is beyond the convertible range.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "daopc_params.svh"
module daopc_top #(
   parameter int unsigned SLEEP_WAKE = `DAOPC_SLEEP_WAKE_CYCLES
) (
   input  wire logic                      core_clk,             // Core clock, 125 MHz
   input  wire logic                      sys_rst,              // Synchronous reset, high
   input  wire logic                      hsel,                 // AHB slave select
   input  wire logic [31:0]               haddr,                // AHB address
   input  wire logic [1:0]                htrans,               // AHB transfer type
   input  wire logic                      hwrite,               // AHB write
   input  wire logic [2:0]                hsize,                // AHB size
   input  wire logic [31:0]               hwdata,               // AHB write data
   input  wire logic                      hready,               // AHB bus ready
   output logic                           hreadyout,            // AHB slave ready
   output logic [31:0]                    hrdata,               // AHB read data
   output logic                           hresp,                // AHB response
   input  wire logic                      chan_a_sample_clock,  // Channel A sample clock pin
   input  wire logic                      chan_b_sample_clock,  // Channel B sample clock pin
   input  wire logic [`DAOPC_WORD_W-1:0]  chan_a_core_code,     // Channel A code from core
   input  wire logic                      chan_a_above_range,   // Channel A over range
   input  wire logic                      chan_a_below_range,   // Channel A under range
   input  wire logic [`DAOPC_WORD_W-1:0]  chan_b_core_code,     // Channel B code from core
   input  wire logic                      chan_b_above_range,   // Channel B over range
   input  wire logic                      chan_b_below_range,   // Channel B under range
   output logic [`DAOPC_WORD_W-1:0]       bus_a_sample_word,    // Bus A data
   output logic                           bus_a_overrange_flag, // Bus A overrange
   output logic                           bus_a_drive_n,        // Bus A enable, low drives
   output logic [`DAOPC_WORD_W-1:0]       bus_b_sample_word,    // Bus B data
   output logic                           bus_b_overrange_flag, // Bus B overrange
   output logic                           bus_b_drive_n,        // Bus B enable, low drives
   output logic                           chan_a_ref_on,        // Channel A reference powered
   output logic                           chan_b_ref_on,        // Channel B reference powered
   output logic                           irq                   // Interrupt, level high
);
   daopc_chan_if cha ();
   daopc_chan_if chb ();

   logic [`DAOPC_CTRL_W-1:0] ctrl_ff;
   logic [`DAOPC_IRQ_W-1:0]  stat_ff;
   logic [`DAOPC_IRQ_W-1:0]  mask_ff;
   logic [`DAOPC_IRQ_W-1:0]  nxt_stat;
   logic [`DAOPC_IRQ_W-1:0]  ev_prev_ff;
   logic [`DAOPC_IRQ_W-1:0]  ev_now;
   logic [1:0]               clk_s1_ff;
   logic [1:0]               clk_s2_ff;
   logic [1:0]               clk_s3_ff;
   logic                     swap_eff;
   logic                     wr_pend_ff;
   logic                     rd_pend_ff;
   logic [7:0]               acc_addr_ff;
   logic                     wr_ok;
   logic [31:0]              rd_mux;
   logic                     hreadyout_ff;
   logic [31:0]              hrdata_ff;
   logic                     irq_ff;
   logic [`DAOPC_WORD_W-1:0] bus_a_word_ff;
   logic [`DAOPC_WORD_W-1:0] bus_b_word_ff;
   logic                     bus_a_of_ff;
   logic                     bus_b_of_ff;
   logic                     bus_a_drive_n_ff;
   logic                     bus_b_drive_n_ff;
   logic                     ref_a_ff;
   logic                     ref_b_ff;

   // ----------------------------------------
   // Sample clock pins
   // ----------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         clk_s1_ff <= 2'h0;
         clk_s2_ff <= 2'h0;
         clk_s3_ff <= 2'h0;
      end else begin
         clk_s1_ff <= {chan_b_sample_clock, chan_a_sample_clock};
         clk_s2_ff <= clk_s1_ff;
         clk_s3_ff <= clk_s2_ff;
      end
   end

   // Interleaving ties the swap to the common sample clock level.
   assign swap_eff = ctrl_ff[`DAOPC_CTRL_SWAP_CLK] ? clk_s2_ff[0]
                                                   : ctrl_ff[`DAOPC_CTRL_SWAP]; // [R11]

   // ----------------------------------------
   // Channels
   // ----------------------------------------
   assign cha.sample_en = clk_s2_ff[0] && !clk_s3_ff[0];
   assign cha.pd        = ctrl_ff[`DAOPC_CTRL_A_PD]; // [R08]
   assign cha.hz        = ctrl_ff[`DAOPC_CTRL_A_HZ]; // [R08]
   assign cha.code      = chan_a_core_code;
   assign cha.above     = chan_a_above_range;
   assign cha.below     = chan_a_below_range;
   assign chb.sample_en = clk_s2_ff[1] && !clk_s3_ff[1];
   assign chb.pd        = ctrl_ff[`DAOPC_CTRL_B_PD]; // [R08]
   assign chb.hz        = ctrl_ff[`DAOPC_CTRL_B_HZ]; // [R08]
   assign chb.code      = chan_b_core_code;
   assign chb.above     = chan_b_above_range;
   assign chb.below     = chan_b_below_range;

   daopc_chan #(.SLEEP_WAKE(SLEEP_WAKE)) u_chan_a (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .ch       (cha)
   );
   daopc_chan #(.SLEEP_WAKE(SLEEP_WAKE)) u_chan_b (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .ch       (chb)
   );

   // ----------------------------------------
   // Output buses
   // ----------------------------------------
   // Each bus's pins float by the controls of the channel that owns them,
   // so the unused bus in interleaving can be parked.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bus_a_word_ff    <= '0;
         bus_b_word_ff    <= '0;
         bus_a_of_ff      <= 1'b0;
         bus_b_of_ff      <= 1'b0;
         bus_a_drive_n_ff <= 1'b1;
         bus_b_drive_n_ff <= 1'b1;
      end else begin
         bus_a_word_ff    <= swap_eff ? cha.word : chb.word; // [R09] [R10]
         bus_a_of_ff      <= swap_eff ? cha.of : chb.of; // [R09] [R10]
         bus_b_word_ff    <= swap_eff ? chb.word : cha.word; // [R09] [R10]
         bus_b_of_ff      <= swap_eff ? chb.of : cha.of; // [R09] [R10]
         bus_a_drive_n_ff <= !cha.out_en; // [R01] [R12]
         bus_b_drive_n_ff <= !chb.out_en; // [R01] [R12]
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ref_a_ff <= 1'b1;
         ref_b_ff <= 1'b1;
      end else begin
         ref_a_ff <= cha.ref_on;
         ref_b_ff <= chb.ref_on;
      end
   end

   // ----------------------------------------
   // Register access
   // ----------------------------------------
   // Reads insert one wait state so that a write just before is visible.
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_pend_ff   <= 1'b0;
         rd_pend_ff   <= 1'b0;
         acc_addr_ff  <= 8'h00;
         hreadyout_ff <= 1'b1;
         hrdata_ff    <= 32'h0000_0000;
      end else begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         if (rd_pend_ff) begin
            hrdata_ff    <= rd_mux;
            hreadyout_ff <= 1'b1;
         end else if (hsel && htrans[1] && hready) begin
            acc_addr_ff  <= haddr[7:0];
            wr_pend_ff   <= hwrite && (hsize == 3'h2);
            rd_pend_ff   <= !hwrite;
            hreadyout_ff <= hwrite;
         end
      end
   end

   assign wr_ok = wr_pend_ff && (acc_addr_ff[1:0] == 2'h0);

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (acc_addr_ff)
         `DAOPC_OFS_CTRL:     rd_mux[`DAOPC_CTRL_W-1:0] = ctrl_ff;
         `DAOPC_OFS_STATUS:   rd_mux[5:0] = {chb.valid, chb.mode, cha.valid, cha.mode};
         `DAOPC_OFS_IRQ_STAT: rd_mux[`DAOPC_IRQ_W-1:0] = stat_ff;
         `DAOPC_OFS_IRQ_MASK: rd_mux[`DAOPC_IRQ_W-1:0] = mask_ff;
         default:             rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) ctrl_ff <= `DAOPC_CTRL_RESET;
      else if (wr_ok && acc_addr_ff == `DAOPC_OFS_CTRL) ctrl_ff <= hwdata[`DAOPC_CTRL_W-1:0];
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) mask_ff <= '0;
      else if (wr_ok && acc_addr_ff == `DAOPC_OFS_IRQ_MASK) mask_ff <= hwdata[`DAOPC_IRQ_W-1:0];
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign ev_now = {chb.of, cha.of, chb.valid, cha.valid};

   // An event in the cycle of its clear wins over the clear.
   always_comb begin
      nxt_stat = stat_ff;
      if (wr_ok && acc_addr_ff == `DAOPC_OFS_IRQ_STAT) nxt_stat = stat_ff & ~hwdata[`DAOPC_IRQ_W-1:0];
      nxt_stat = nxt_stat | (ev_now & ~ev_prev_ff);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         stat_ff    <= '0;
         // Both channels leave reset normal and valid, so no ready event follows reset.
         ev_prev_ff <= 4'h3;
         irq_ff     <= 1'b0;
      end else begin
         stat_ff    <= nxt_stat;
         ev_prev_ff <= ev_now;
         irq_ff     <= |(nxt_stat & mask_ff);
      end
   end

   assign hreadyout            = hreadyout_ff;
   assign hrdata               = hrdata_ff;
   assign hresp                = 1'b0;
   assign irq                  = irq_ff;
   assign bus_a_sample_word    = bus_a_word_ff;
   assign bus_b_sample_word    = bus_b_word_ff;
   assign bus_a_overrange_flag = bus_a_of_ff;
   assign bus_b_overrange_flag = bus_b_of_ff;
   assign bus_a_drive_n        = bus_a_drive_n_ff;
   assign bus_b_drive_n        = bus_b_drive_n_ff;
   assign chan_a_ref_on        = ref_a_ff;
   assign chan_b_ref_on        = ref_b_ff;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   swap_high_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R09]
      swap_eff |=> bus_a_sample_word == $past(cha.word) &&
                   bus_b_overrange_flag == $past(chb.of))
      else $error("Straight routing wrong.");
   swap_low_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R10]
      !swap_eff |=> bus_b_sample_word == $past(cha.word) &&
                    bus_a_overrange_flag == $past(chb.of))
      else $error("Swapped routing wrong.");
   bus_own_ctl_a: assert property (@(posedge core_clk) disable iff (sys_rst) // [R08]
      (cha.hz && !chb.hz && !chb.pd)[*3] |-> bus_a_drive_n && !bus_b_drive_n)
      else $error("Channel controls leaked across.");
   clear_set_a: assert property (@(posedge core_clk) disable iff (sys_rst)
      (ev_now[0] && !ev_prev_ff[0]) |=> stat_ff[0])
      else $error("Ready event lost.");
endmodule : daopc_top
`default_nettype wire

// ===== daopc_latch_model.sv
// Receiving latch on one output bus of the converter control block.
// Assumes drive_n low means the block drives the pins.
`timescale 1ns/1ps
`default_nettype none
`include "daopc_params.svh"
module daopc_latch_model (
   input  wire logic                     core_clk,  // Core clock
   input  wire logic                     drive_n,   // Bus enable, low drives
   input  wire logic [`DAOPC_WORD_W-1:0] word_pins, // Bus data pins
   input  wire logic                     flag_pins, // Bus overrange pin
   output logic      [`DAOPC_WORD_W:0]   line_view  // Level seen on the wires
);
   logic [`DAOPC_WORD_W:0] last_ff;
   // A floated bus has no pull, so it shows the inverse of its last level.
   assign line_view = drive_n ? ~last_ff : {flag_pins, word_pins};
   always_ff @(posedge core_clk) begin
      if (!drive_n) last_ff <= {flag_pins, word_pins};
   end
endmodule : daopc_latch_model
`default_nettype wire

// ===== dual_adc_output_power_ctrl_bench.sv
// Self-checking bench of the output and power control block.
// Assumes the design files and the latch model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "daopc_params.svh"
module dual_adc_output_power_ctrl_bench;
   logic        core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic        clk_a = 1'b0, clk_b = 1'b0, a_up = 1'b0, a_lo = 1'b0, b_up = 1'b0, b_lo = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [9:0]  ca = 10'h0, cb = 10'h0, wa, wb;
   logic [10:0] va, vb;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rng = 32'h20b9;
   logic        hreadyout, hresp, fa, fb, a_dn, b_dn, ref_a, ref_b, irq;
   int          errors = 0, tests_run = 0, cyc = 0;
   daopc_top #(.SLEEP_WAKE(20)) i_daopc_top (.core_clk(core_clk), .sys_rst(sys_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .chan_a_sample_clock(clk_a), .chan_b_sample_clock(clk_b),
      .chan_a_core_code(ca), .chan_a_above_range(a_up), .chan_a_below_range(a_lo),
      .chan_b_core_code(cb), .chan_b_above_range(b_up), .chan_b_below_range(b_lo),
      .bus_a_sample_word(wa), .bus_a_overrange_flag(fa), .bus_a_drive_n(a_dn),
      .bus_b_sample_word(wb), .bus_b_overrange_flag(fb), .bus_b_drive_n(b_dn),
      .chan_a_ref_on(ref_a), .chan_b_ref_on(ref_b), .irq(irq));
   daopc_latch_model i_daopc_latch_model_a (.core_clk(core_clk), .drive_n(a_dn),
      .word_pins(wa), .flag_pins(fa), .line_view(va));
   daopc_latch_model i_daopc_latch_model_b (.core_clk(core_clk), .drive_n(b_dn),
      .word_pins(wb), .flag_pins(fb), .line_view(vb));
   initial forever #4 core_clk = ~core_clk;
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   // ------------------------------------------------------------
   // Bus cycles and comparisons
   // ------------------------------------------------------------
   task automatic end_sim();
      if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      {hsel, hwrite, haddr, htrans} <= {1'b1, w, a, 2'b10};
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
      @(posedge core_clk);
      while (hreadyout !== 1'b1) @(posedge core_clk);
      rd = hrdata;
   endtask : ahb
   // Both sample pins rise together, as an interleaving board would wire them.
   task automatic samp();
      rng = xs(rng);
      {a_up, a_lo, ca, b_up, b_lo, cb} <= rng[23:0];
      @(posedge core_clk);
      {clk_a, clk_b} <= 2'b11;
      repeat (4) @(posedge core_clk);
      {clk_a, clk_b} <= 2'b00;
      repeat (5) @(posedge core_clk);
   endtask : samp
   function automatic logic [31:0] pick(input logic sw, input logic bus_b);
      return (sw ^ bus_b) ? {a_up | a_lo, ca} : {b_up | b_lo, cb};
   endfunction : pick
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         errors++;
         end_sim();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      chk("reset hresp ref_a irq", {hresp, ref_a, irq}, 32'h2);
      ahb(0, `DAOPC_OFS_CTRL, 0);
      chk("ctrl reset", rd, 32'h10);
      ahb(0, 32'h10, 0);
      chk("unmapped read", rd, 32'h0);
      ahb(0, `DAOPC_OFS_IRQ_STAT, 0);
      chk("stat after reset", rd, 32'h0);
      for (int i = 0; i < 4; i++) begin
         ahb(1, `DAOPC_OFS_CTRL, i[0] ? 32'h10 : 32'h0);
         samp();
         chk("bus a", va, pick(i[0], 0));
         chk("bus b", vb, pick(i[0], 1));
      end
      ahb(1, `DAOPC_OFS_CTRL, 32'h30);
      samp();
      chk("follow clk bus a", va, pick(0, 0));
      chk("follow clk bus b", vb, pick(0, 1));
      ahb(1, `DAOPC_OFS_CTRL, 32'h12);
      samp();
      chk("hz a drive_n", {a_dn, b_dn}, 32'h2);
      chk("bus b in hz a", vb, pick(1, 1));
      ahb(1, `DAOPC_OFS_IRQ_MASK, 32'h3);
      ahb(1, `DAOPC_OFS_CTRL, 32'h11);
      repeat (3) @(posedge core_clk);
      chk("nap drive ref", {a_dn, ref_a}, 32'h3);
      ahb(0, `DAOPC_OFS_STATUS, 0);
      chk("nap mode", rd & 32'h3, 32'h1);
      ahb(1, `DAOPC_OFS_CTRL, 32'h10);
      repeat (99) samp();
      ahb(0, `DAOPC_OFS_STATUS, 0);
      chk("nap valid early", rd[2], 32'h0);
      samp();
      ahb(0, `DAOPC_OFS_STATUS, 0);
      chk("nap valid", {rd[2], irq}, 32'h3);
      chk("bus a after nap", va, pick(1, 0));
      ahb(1, `DAOPC_OFS_IRQ_STAT, 32'hf);
      ahb(1, `DAOPC_OFS_IRQ_MASK, 32'h0);
      chk("irq cleared", irq, 32'h0);
      ahb(1, `DAOPC_OFS_CTRL, 32'h1c);
      repeat (3) @(posedge core_clk);
      chk("sleep b pins", {ref_b, b_dn, a_dn}, 32'h2);
      ahb(0, `DAOPC_OFS_STATUS, 0);
      chk("sleep mode", rd[4:3], 32'h2);
      ahb(1, `DAOPC_OFS_CTRL, 32'h10);
      ahb(0, `DAOPC_OFS_STATUS, 0);
      chk("sleep valid early", rd[5], 32'h0);
      repeat (25) @(posedge core_clk);
      ahb(0, `DAOPC_OFS_STATUS, 0);
      chk("sleep valid", {rd[5], irq}, 32'h2);
      ahb(0, `DAOPC_OFS_IRQ_STAT, 0);
      chk("b ready sticky", rd[1], 32'h1);
      ahb(1, `DAOPC_OFS_IRQ_MASK, 32'h2);
      repeat (2) @(posedge core_clk);
      chk("irq unmasked", irq, 32'h1);
      end_sim();
   end
endmodule : dual_adc_output_power_ctrl_bench
`default_nettype wire
